// [include/rem_pkg.sv]
// package for the return electrode monitor: timing, layout, register map.
// assumes a single 20 MHz core clock shared by every user of the package.
package rem_pkg;
    // clock and measurement timing
    localparam int CLK_HZ        = 20_000_000;
    localparam int INTERVAL_MS   = 12;
    localparam int INTERVAL_CYC  = INTERVAL_MS * (CLK_HZ / 1000);
    localparam int BLINK_MS      = 250;
    localparam int BLINK_CYC     = BLINK_MS * (CLK_HZ / 1000);
    localparam int SETTLE_NS     = 500;
    localparam int SETTLE_CYC    = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // dac: 8 bits spanning 0 .. 2550 mV in 10 mV steps
    localparam int DAC_BITS      = 8;
    localparam int DAC_FULL_MV   = 2550;
    localparam int DAC_STEP_MV   = DAC_FULL_MV / ((1 << DAC_BITS) - 1);

    // running average
    localparam int AVG_DEPTH     = 50;
    localparam int AVG_SHIFT     = 16;

    // bar indicator
    localparam int BAR_COUNT     = 10;
    localparam int BAR_FLOOR     = 2;
    localparam int BAR_STEPS     = 6;

    // rise threshold: ln(1.2)/ln(15) of the calibrated span, as 69/1024
    localparam int RISE_NUM      = 69;
    localparam int RISE_SHIFT    = 10;

    // register byte offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_CAL    = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_BARS   = 4'hC;

    // field positions
    localparam int CTRL_DUAL     = 0;
    localparam int CTRL_KEY      = 1;
    localparam int CAL10_LSB     = 0;
    localparam int CAL150_LSB    = 8;
    localparam int ST_FAULT      = 0;
    localparam int ST_RISE       = 1;
    localparam int ST_REF        = 2;
    localparam int ST_HS         = 3;
    localparam int ST_AVGV       = 4;
    localparam int ST_SAMPLE_LSB = 8;
    localparam int ST_AVG_LSB    = 16;
    localparam int ST_REF_LSB    = 24;

    // calibration store reset contents (plain defaults)
    localparam logic [7:0] CAL10_RST  = 8'h64;
    localparam logic [7:0] CAL150_RST = 8'hC8;

    typedef enum logic [1:0] {
        REM_SAR_IDLE   = 2'b00,
        REM_SAR_SETTLE = 2'b01,
        REM_SAR_DECIDE = 2'b10
    } rem_sar_t;
endpackage

// [rtl/rem_avg.sv]
// running mean over the latest samples of the sense voltage.
// assumes sample_vld is a one-cycle pulse on core_clk from the converter.
`timescale 1ns/100ps
module rem_avg #(
    parameter int DEPTH = rem_pkg::AVG_DEPTH
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       reset,
    // new sample
    input  wire logic [7:0] sample,
    input  wire logic       sample_vld,
    // mean
    output logic [7:0]      mean,
    output logic            mean_vld
);
    import rem_pkg::*;

    localparam int IW    = $clog2(DEPTH);
    localparam int SW    = $clog2(DEPTH * 256);
    localparam int RECIP = ((1 << AVG_SHIFT) + DEPTH - 1) / DEPTH;

    typedef struct packed {
        logic [DEPTH-1:0][7:0] hist;
        logic [IW-1:0]         wptr;
        logic [SW-1:0]         sum;
        logic [7:0]            mean;
        logic                  full;
    } rem_avg_st_t;

    rem_avg_st_t st_r;
    rem_avg_st_t st_nxt;
    logic [SW-1:0] sum_tmp;
    logic [31:0]   prod;

    // oldest sample leaves the sum as the new one enters
    always_comb begin
        st_nxt  = st_r;
        sum_tmp = st_r.sum + SW'(sample) - SW'(st_r.hist[st_r.wptr]);
        prod    = 32'(sum_tmp) * 32'(RECIP);
        if (sample_vld) begin
            st_nxt.hist[st_r.wptr] = sample;
            st_nxt.sum             = sum_tmp;
            st_nxt.mean            = prod[AVG_SHIFT +: 8];
            if (st_r.wptr == IW'(DEPTH - 1)) begin
                st_nxt.wptr = '0;
                st_nxt.full = 1'b1;
            end else begin
                st_nxt.wptr = st_r.wptr + 1'b1;
            end
        end
    end

    // history cleared at reset so a partial window never reads stale data
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mean     = st_r.mean;
    assign mean_vld = st_r.full;

    property p_mean_hold;
        @(posedge core_clk) disable iff (reset)
        !sample_vld |=> $stable(mean);
    endproperty
    a_mean_hold: assert property (p_mean_hold) else $error("mean moved without a sample");
endmodule

// [rtl/rem_top.sv]
// return electrode monitor: sar conversion, averaging, fault and bar logic.
// assumes an external dac, a comparator on sense_above and an Avalon-MM master.
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
module rem_top #(
    parameter int INTERVAL_CYCLES = rem_pkg::INTERVAL_CYC,
    parameter int BLINK_CYCLES    = rem_pkg::BLINK_CYC
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // sense converter
    output logic [7:0]       dac_code,
    input  wire logic        sense_above,
    // handswitch and indicators
    input  wire logic        bipolar_handswitch_n,
    output logic             handswitch_closed,
    output logic [9:0]       resistance_bar_display,
    output logic             return_fault
);
    import rem_pkg::*;

    localparam int TW = $clog2(INTERVAL_CYCLES);
    localparam int BW = $clog2(BLINK_CYCLES);
    localparam int KW = $clog2(SETTLE_CYC + 1);

    typedef struct packed {
        logic [2:0]    cmp_sync;
        logic          cmp_f;
        logic [2:0]    hs_sync;
        logic          hs_closed;
        logic [TW-1:0] tick;
        rem_sar_t      sar;
        logic [KW-1:0] settle;
        logic [2:0]    bit_idx;
        logic [7:0]    result;
        logic [7:0]    dac;
        logic          sample_vld;
        logic [7:0]    sample;
        logic          dual;
        logic [7:0]    cal10;
        logic [7:0]    cal150;
        logic [7:0]    ref_val;
        logic          ref_vld;
        logic          rise;
        logic          fault;
        logic [3:0]    bar_cnt;
        logic [9:0]    bars;
        logic          blink;
        logic [BW-1:0] blink_cnt;
        logic          wait_r;
        logic [31:0]   rdata;
    } rem_st_t;

    rem_st_t     st_r;
    rem_st_t     st_nxt;
    logic [7:0]  avg;
    logic        avg_vld;
    logic        key;
    logic [7:0]  span;
    logic        below;
    logic        above;
    logic        rise_hit;
    logic [7:0]  kept;

    // threshold k of BAR_STEPS between the two calibration points
    function automatic logic [7:0] rem_thr(input logic [7:0] lo, input logic [7:0] sp, input int k);
        logic [15:0] p;
        p = (16'(sp) * 16'(k)) / 16'(BAR_STEPS);
        return lo + p[7:0];
    endfunction

    // leftmost n bars lit, bit 0 is the leftmost bar
    function automatic logic [9:0] rem_mask(input logic [3:0] n);
        logic [9:0] m;
        m = '0;
        for (int i = 0; i < BAR_COUNT; i++) begin
            if (4'(i) < n) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    rem_avg #(
        .DEPTH(AVG_DEPTH)
    ) u_avg (
        .core_clk  (core_clk),
        .reset     (reset),
        .sample    (st_r.sample),
        .sample_vld(st_r.sample_vld),
        .mean      (avg),
        .mean_vld  (avg_vld)
    );

    // calibration span and comparisons in the sense-voltage domain
    always_comb begin
        logic [15:0] mp;
        mp       = '0;
        span     = (st_r.cal150 > st_r.cal10) ? (st_r.cal150 - st_r.cal10) : 8'h00;
        below    = avg < st_r.cal10;
        above    = avg > st_r.cal150;
        // sense tracks log of resistance, so a 20 percent rise is a fixed step
        mp       = (16'(span) * 16'(RISE_NUM)) >> RISE_SHIFT;
        rise_hit = st_r.ref_vld && ({1'b0, avg} > ({1'b0, st_r.ref_val} + {1'b0, mp[7:0]}));
        kept     = st_r.cmp_f ? st_r.dac : st_r.result;
        key      = avs_write && !st_r.wait_r && (avs_address == REG_CTRL)
                   && avs_byteenable[0] && avs_writedata[CTRL_KEY];
    end

    // next state for converter, bus, faults and display
    always_comb begin
        logic [3:0] n;
        logic       tick_done;
        st_nxt    = st_r;
        n         = '0;
        tick_done = (st_r.tick == TW'(INTERVAL_CYCLES - 1));

        // pins pass three flops; a change counts when the last two agree
        st_nxt.cmp_sync = {st_r.cmp_sync[1:0], sense_above};
        if (st_r.cmp_sync[1] == st_r.cmp_sync[2]) begin
            st_nxt.cmp_f = st_r.cmp_sync[2];
        end
        st_nxt.hs_sync = {st_r.hs_sync[1:0], bipolar_handswitch_n};
        if (st_r.hs_sync[1] == st_r.hs_sync[2]) begin
            st_nxt.hs_closed = !st_r.hs_sync[2];
        end

        // measurement interval
        st_nxt.tick       = tick_done ? '0 : st_r.tick + 1'b1;
        st_nxt.sample_vld = 1'b0;

        // successive approximation; settle covers dac slew and the pin flops
        case (st_r.sar)
            REM_SAR_IDLE: begin
                if (tick_done) begin
                    st_nxt.sar     = REM_SAR_SETTLE;
                    st_nxt.bit_idx = 3'h7;
                    st_nxt.result  = 8'h00;
                    st_nxt.dac     = 8'h80;
                    st_nxt.settle  = '0;
                end
            end
            REM_SAR_SETTLE: begin
                st_nxt.settle = st_r.settle + 1'b1;
                if (st_r.settle == KW'(SETTLE_CYC - 1)) begin
                    st_nxt.sar = REM_SAR_DECIDE;
                end
            end
            REM_SAR_DECIDE: begin
                if (st_r.bit_idx == 3'h0) begin
                    st_nxt.sample     = kept;
                    st_nxt.sample_vld = 1'b1;
                    st_nxt.result     = kept;
                    st_nxt.dac        = kept;
                    st_nxt.sar        = REM_SAR_IDLE;
                end else begin
                    st_nxt.result  = kept;
                    st_nxt.bit_idx = st_r.bit_idx - 3'h1;
                    st_nxt.dac     = kept | (8'h01 << (st_r.bit_idx - 3'h1));
                    st_nxt.settle  = '0;
                    st_nxt.sar     = REM_SAR_SETTLE;
                end
            end
            default: begin
                st_nxt.sar = REM_SAR_IDLE;
            end
        endcase

        // avalon: one wait cycle, then a one-cycle answer
        st_nxt.wait_r = 1'b1;
        if ((avs_read || avs_write) && st_r.wait_r) begin
            st_nxt.wait_r = 1'b0;
            st_nxt.rdata  = 32'h0000_0000;
            case (avs_address)
                REG_CTRL: begin
                    st_nxt.rdata[CTRL_DUAL] = st_r.dual;
                end
                REG_CAL: begin
                    st_nxt.rdata[CAL10_LSB +: 8]  = st_r.cal10;
                    st_nxt.rdata[CAL150_LSB +: 8] = st_r.cal150;
                end
                REG_STATUS: begin
                    st_nxt.rdata[ST_FAULT]           = st_r.fault;
                    st_nxt.rdata[ST_RISE]            = st_r.rise;
                    st_nxt.rdata[ST_REF]             = st_r.ref_vld;
                    st_nxt.rdata[ST_HS]              = st_r.hs_closed;
                    st_nxt.rdata[ST_AVGV]            = avg_vld;
                    st_nxt.rdata[ST_SAMPLE_LSB +: 8] = st_r.sample;
                    st_nxt.rdata[ST_AVG_LSB +: 8]    = avg;
                    st_nxt.rdata[ST_REF_LSB +: 8]    = st_r.ref_val;
                end
                REG_BARS: begin
                    st_nxt.rdata[3:0] = st_r.bar_cnt;
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
        // writes land on the edge where the master sees waitrequest low
        if (avs_write && !st_r.wait_r) begin
            if (avs_address == REG_CTRL && avs_byteenable[0]) begin
                st_nxt.dual = avs_writedata[CTRL_DUAL];
                if (avs_writedata[CTRL_DUAL] != st_r.dual) begin
                    // a changed pad type voids the stored reference
                    st_nxt.ref_vld = 1'b0;
                    st_nxt.rise    = 1'b0;
                end
            end
            if (avs_address == REG_CAL) begin
                if (avs_byteenable[CAL10_LSB / 8]) begin
                    st_nxt.cal10 = avs_writedata[CAL10_LSB +: 8];
                end
                if (avs_byteenable[CAL150_LSB / 8]) begin
                    st_nxt.cal150 = avs_writedata[CAL150_LSB +: 8];
                end
            end
        end

        // set-point key: store reference and drop the latched rise
        if (key && st_r.dual && avg_vld && !below && !above) begin
            st_nxt.ref_val = avg;
            st_nxt.ref_vld = 1'b1;
            st_nxt.rise    = 1'b0;
        end
        // rise is checked against the old reference; a hit wins over the key
        if (st_r.dual && avg_vld && rise_hit) begin
            st_nxt.rise = 1'b1;
        end

        // fault evaluation only once the averaging window is full
        if (!avg_vld) begin
            st_nxt.fault = 1'b0;
        end else if (st_r.dual) begin
            st_nxt.fault = below || above || st_nxt.rise;
        end else begin
            st_nxt.fault = !below;
        end

        // bar count in sense-voltage steps between calibration points
        if (!st_r.dual || !avg_vld) begin
            n = 4'h0;
        end else if (below) begin
            n = 4'h0;
        end else if (above) begin
            n = 4'(BAR_COUNT);
        end else begin
            n = 4'(BAR_FLOOR);
            for (int k = 1; k <= BAR_STEPS; k++) begin
                if (avg >= rem_thr(st_r.cal10, span, k)) begin
                    n = n + 4'h1;
                end
            end
        end
        st_nxt.bar_cnt = n;

        // flash phase runs freely; while faulted, lit bars blank in the off phase
        if (st_r.blink_cnt == BW'(BLINK_CYCLES - 1)) begin
            st_nxt.blink_cnt = '0;
            st_nxt.blink     = !st_r.blink;
        end else begin
            st_nxt.blink_cnt = st_r.blink_cnt + 1'b1;
        end
        st_nxt.bars = (st_nxt.fault && !st_r.blink) ? 10'h000 : rem_mask(n);
    end

    // single state register; reference, faults and timing all start clear
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r        <= '0;
            st_r.cal10  <= CAL10_RST;
            st_r.cal150 <= CAL150_RST;
            st_r.wait_r <= 1'b1;
            st_r.sar    <= REM_SAR_IDLE;
            st_r.hs_sync <= '1; // idle line is high, so no false closure after reset
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flops
    assign avs_readdata           = st_r.rdata;
    assign avs_waitrequest        = st_r.wait_r;
    assign dac_code               = st_r.dac;
    assign handswitch_closed      = st_r.hs_closed;
    assign resistance_bar_display = st_r.bars;
    assign return_fault           = st_r.fault;

    property p_single_dark;
        @(posedge core_clk) disable iff (reset)
        !st_r.dual |=> resistance_bar_display == 10'h000;
    endproperty
    a_single_dark: assert property (p_single_dark) else $error("bars lit in single foil");

    property p_no_one_nine;
        @(posedge core_clk) disable iff (reset)
        st_r.bar_cnt != 4'h1 && st_r.bar_cnt != 4'h9;
    endproperty
    a_no_one_nine: assert property (p_no_one_nine) else $error("bar count one or nine");

    property p_all_bars;
        @(posedge core_clk) disable iff (reset)
        st_r.dual && avg_vld && above |=> st_r.bar_cnt == 4'hA;
    endproperty
    a_all_bars: assert property (p_all_bars) else $error("ten bars missing above range");

    property p_dark_below;
        @(posedge core_clk) disable iff (reset)
        st_r.dual && avg_vld && below |=> st_r.bar_cnt == 4'h0 && return_fault;
    endproperty
    a_dark_below: assert property (p_dark_below) else $error("below range not dark or no fault");

    property p_single_fault;
        @(posedge core_clk) disable iff (reset)
        !st_r.dual && avg_vld && !below |=> return_fault;
    endproperty
    a_single_fault: assert property (p_single_fault) else $error("single foil fault missing");

    property p_dual_range;
        @(posedge core_clk) disable iff (reset)
        st_r.dual && avg_vld && (below || above) |=> return_fault;
    endproperty
    a_dual_range: assert property (p_dual_range) else $error("dual foil range fault missing");

    property p_rise_latched;
        @(posedge core_clk) disable iff (reset)
        st_r.rise && !key && !(avs_write && !st_r.wait_r && avs_address == REG_CTRL) |=> st_r.rise;
    endproperty
    a_rise_latched: assert property (p_rise_latched) else $error("rise fault dropped without key");

    property p_conv_time;
        @(posedge core_clk) disable iff (reset)
        st_r.sar == REM_SAR_IDLE && st_nxt.sar == REM_SAR_SETTLE |-> ##[1:200] st_r.sample_vld;
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion did not finish");

    property p_flash_blank;
        @(posedge core_clk) disable iff (reset)
        st_nxt.fault && !st_r.blink |=> resistance_bar_display == 10'h000;
    endproperty
    a_flash_blank: assert property (p_flash_blank) else $error("bars not blanked while flashing");

    c_conv_done: cover property (@(posedge core_clk) disable iff (reset) st_r.sample_vld);
    c_setpoint: cover property (@(posedge core_clk) disable iff (reset) key ##1 st_r.ref_vld);
    c_rise: cover property (@(posedge core_clk) disable iff (reset) !st_r.rise ##1 st_r.rise);
    c_ten_bars: cover property (@(posedge core_clk) disable iff (reset) st_r.bar_cnt == 4'hA);
endmodule

// [verification/rem_sense_model.sv]
// sense side model: comparator against the dac level, handswitch line.
// assumes dac_code steps 10 mV and the bench sets the sense level in mV.
`timescale 1ns/100ps
module rem_sense_model (
    // converter side
    input  wire logic [7:0]  dac_code,
    output logic             sense_above,
    // bench controls
    input  wire logic [11:0] sense_mv,
    input  wire logic        hs_closed,
    // handswitch line
    output logic             bipolar_handswitch_n
);
    // one above/below result; equal counts as above
    assign sense_above = (sense_mv >= 12'(dac_code) * 12'h00A);
    // opto pulls low when closed, pull-up holds high when released
    assign bipolar_handswitch_n = hs_closed ? 1'b0 : 1'b1;
endmodule

// [verification/testbench.sv]
// self-checking bench for the return electrode monitor top.
// assumes short interval and blink counts and the sense model beside it.
`timescale 1ns/100ps
module testbench;
    import rem_pkg::*;
    localparam int IVL = 120;
    localparam int BLK = 16;
    // clock, reset and bus
    logic        core_clk;
    logic        reset;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    // sense and indicators
    logic [7:0]  dac_code;
    logic        sense_above;
    logic        bipolar_handswitch_n;
    logic        handswitch_closed;
    logic [9:0]  resistance_bar_display;
    logic        return_fault;
    logic [11:0] sense_mv;
    logic        hs_closed;
    logic [31:0] rd;
    int          err_total;
    int          checked;
    int          v;
    int          hold;

    rem_top #(.INTERVAL_CYCLES(IVL), .BLINK_CYCLES(BLK)) i_dut (
        .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dac_code(dac_code),
        .sense_above(sense_above), .bipolar_handswitch_n(bipolar_handswitch_n),
        .handswitch_closed(handswitch_closed), .resistance_bar_display(resistance_bar_display),
        .return_fault(return_fault));
    rem_sense_model i_model (
        .dac_code(dac_code), .sense_above(sense_above), .sense_mv(sense_mv),
        .hs_closed(hs_closed), .bipolar_handswitch_n(bipolar_handswitch_n));

    // 20 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog, well beyond the ~66k cycles of the sequence
    initial begin
        #4_500_000;
        err_total++;
        complete_run();
    end

    task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_bit(input string nm, input logic e, input logic g);
        check_word(nm, {31'h0, e}, {31'h0, g});
    endtask

    // one avalon access; held until waitrequest is sampled low
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] wd, input logic [3:0] be,
                       output logic [31:0] d);
        avs_address    <= a;
        avs_read       <= ~w;
        avs_write      <= w;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    // expected lit bar count for a settled average in dual foil
    function automatic int nbars(input int a);
        int n;
        int lo;
        int sp;
        lo = int'(CAL10_RST);
        sp = int'(CAL150_RST) - lo;
        if (a < lo)
            return 0;
        if (a > int'(CAL150_RST))
            return 10;
        n = 2;
        for (int k = 1; k <= 6; k++) begin
            if (a >= lo + (sp * k) / 6)
                n++;
        end
        return n;
    endfunction

    // hold one sense code until the 50-sample mean settles, then judge
    task automatic point(input int c, input logic dual, input logic extra);
        int n;
        int on;
        int off;
        int bad;
        logic f;
        logic [9:0] pat;
        sense_mv <= 12'(c * 10 + 5);
        repeat (52 * IVL) @(posedge core_clk);
        n = dual ? nbars(c) : 0;
        f = extra | (dual ? (n == 0 || n == 10) : (c >= int'(CAL10_RST)));
        pat = 10'((1 << n) - 1);
        on = 0;
        off = 0;
        bad = 0;
        for (int i = 0; i < 4 * BLK; i++) begin
            @(posedge core_clk);
            if (resistance_bar_display === pat)
                on++;
            else if (resistance_bar_display === 10'h000)
                off++;
            else
                bad++;
        end
        bus(REG_STATUS, 1'b0, 32'h0, 4'hF, rd);
        check_word("average", 32'(c), 32'(rd[ST_AVG_LSB +: 8]));
        check_bit("status_fault", f, rd[ST_FAULT]);
        check_bit("return_fault", f, return_fault);
        bus(REG_BARS, 1'b0, 32'h0, 4'hF, rd);
        check_word("bar_count", 32'(n), 32'(rd[3:0]));
        check_bit("bar_pattern", 1'b1, bad == 0 && ((f && n > 0) ? (on > 0 && off > 0) : on == 4 * BLK));
    endtask

    initial begin
        reset = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        sense_mv = 12'h000;
        hs_closed = 1'b0;
        err_total = 0;
        checked = 0;
        v = $urandom(32'h0D57);
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        bus(REG_STATUS, 1'b0, 32'h0, 4'hF, rd);
        check_word("status_reset", 32'h0, rd & 32'hFFFF00FF);
        bus(REG_CAL, 1'b0, 32'h0, 4'hF, rd);
        check_word("cal_reset", {16'h0, CAL150_RST, CAL10_RST}, rd);
        // lane 0 only: the 150 ohm point must survive, then restore both
        bus(REG_CAL, 1'b1, 32'h0000_3355, 4'h1, rd);
        bus(REG_CAL, 1'b0, 32'h0, 4'hF, rd);
        check_word("cal_write", {16'h0, CAL150_RST, 8'h55}, rd);
        bus(REG_CAL, 1'b1, {16'h0, CAL150_RST, CAL10_RST}, 4'h3, rd);
        bus(4'h1, 1'b0, 32'h0, 4'hF, rd);
        check_word("unmapped", 32'h0, rd);
        // full-scale and zero corners, then random levels
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 2549 : (i == 1) ? 0 : $urandom_range(2549, 0);
            sense_mv <= 12'(v);
            hs_closed <= 1'($urandom_range(1, 0));
            repeat (2 * IVL) @(posedge core_clk);
            bus(REG_STATUS, 1'b0, 32'h0, 4'hF, rd);
            check_word("sample", 32'(v / 10), 32'(rd[ST_SAMPLE_LSB +: 8]));
            // final code stands only from the last decision to the next interval
            hold = 0;
            repeat (IVL) begin
                @(posedge core_clk);
                hold += (dac_code === 8'(v / 10)) ? 1 : 0;
            end
            check_bit("dac_hold", 1'b1, hold >= IVL - DAC_BITS * (SETTLE_CYC + 1));
            check_bit("handswitch", hs_closed, handswitch_closed);
        end
        point(99, 1'b0, 1'b0);
        point(100, 1'b0, 1'b0);
        bus(REG_CTRL, 1'b1, 32'h1, 4'h1, rd);
        bus(REG_CTRL, 1'b1, 32'h0, 4'hE, rd);
        bus(REG_CTRL, 1'b0, 32'h0, 4'hF, rd);
        check_word("ctrl", 32'h1, rd);
        point(90, 1'b1, 1'b0);
        point(100, 1'b1, 1'b0);
        point($urandom_range(199, 101), 1'b1, 1'b0);
        point(200, 1'b1, 1'b0);
        point(201, 1'b1, 1'b0);
        point(130, 1'b1, 1'b0);
        bus(REG_CTRL, 1'b1, 32'h3, 4'h1, rd);
        bus(REG_STATUS, 1'b0, 32'h0, 4'hF, rd);
        check_bit("ref_valid", 1'b1, rd[ST_REF]);
        check_word("ref_value", 32'd130, 32'(rd[ST_REF_LSB +: 8]));
        // ref + floor(span*69/1024) is 136, so 137 trips the rise
        point(137, 1'b1, 1'b1);
        point(130, 1'b1, 1'b1);
        bus(REG_CTRL, 1'b1, 32'h3, 4'h1, rd);
        repeat (4) @(posedge core_clk);
        check_bit("fault_cleared", 1'b0, return_fault);
        // second reset mid-run clears reference, mean and faults
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        bus(REG_STATUS, 1'b0, 32'h0, 4'hF, rd);
        check_word("status_rereset", 32'h0, rd & 32'hFFFF00F7);
        check_bit("fault_rereset", 1'b0, return_fault);
        complete_run();
    end
endmodule
